// ### include/orc_defs.svh
`ifndef ORC_DEFS_SVH
`define ORC_DEFS_SVH
// Transceiver-side register addresses
`define ORC_DRC_WR       6'h0a
`define ORC_DRC_SET      6'h0b
`define ORC_DRC_CLR      6'h0c
`define ORC_REE_WR       6'h0d
`define ORC_REE_SET      6'h0e
`define ORC_REE_CLR      6'h0f
// Dual-role control fields
`define ORC_B_ID_SENSE   0
`define ORC_B_DP_PD      1
`define ORC_B_DM_PD      2
`define ORC_B_DISCHARGE  3
`define ORC_B_CHARGE     4
`define ORC_B_SWITCH     6
`define ORC_B_EXT_IND    7
`define ORC_DRC_RESET    8'h06
`define ORC_DRC_MASK     8'hdf
// Rising enable: detach, supply valid, session present, ended, id grounded
`define ORC_EV_DETACH    0
`define ORC_EV_VALID     1
`define ORC_EV_SESSION   2
`define ORC_EV_ENDED     3
`define ORC_EV_ID_GND    4
`define ORC_REE_RESET    8'h1f
`define ORC_REE_MASK     8'h1f
// Receive status byte: bit 7 event, bits 6:5 line state, bits 4:0 sources
`define ORC_RX_EVENT     7
`define ORC_RX_LS_LO     5
// Controller Wishbone byte addresses
`define ORC_WB_CMD       8'h00
`define ORC_WB_STATUS    8'h04
`define ORC_WB_IRQ_STAT  8'h08
`define ORC_WB_IRQ_CLR   8'h0c
`define ORC_WB_IRQ_EN    8'h10
`define ORC_CMD_WE       16
`define ORC_IRQ_DONE     0
`define ORC_IRQ_EVENT    1
`define ORC_IRQ_REFUSED  2
`define ORC_IRQ_DISCH    3
// Timing
`define ORC_CLK_HZ       25000000
`define ORC_ID_SETTLE_MS 50
`define ORC_SE0_MIN_MS   2
`endif

// ### include/orc_pkg.sv
package orc_pkg;
  typedef enum logic [1:0] {
    OP_WRITE = 2'h0,
    OP_SET   = 2'h1,
    OP_CLEAR = 2'h2,
    OP_NONE  = 2'h3
  } orc_op_type;
  typedef enum logic [2:0] {
    ST_IDLE = 3'b001,
    ST_BUSY = 3'b010,
    ST_GAP  = 3'b100
  } orc_state_type;
endpackage

// ### include/orc_if.sv
`timescale 1ns/10ps
interface orc_if;
  logic       req;
  logic       we;
  logic [5:0] addr;
  logic [7:0] wdata;
  logic       ack;
  logic [7:0] rdata;
  logic       rx_valid;
  logic [7:0] rx_byte;
  modport phy (input req, we, addr, wdata, output ack, rdata, rx_valid, rx_byte);
  modport link (output req, we, addr, wdata, input ack, rdata, rx_valid, rx_byte);
endinterface

// ### logic/orc_phy_regs.sv
// Summary of operation
// - control register written, set, cleared at three addresses
// - rising enables written, set, cleared at three addresses
// - bit 0 attaches id pull-up, enables sampling
// - bits 1,2 attach line pull-downs, reset one
// - bit 3 discharges supply line while set
// - controller holds discharge until session ended rises
// - bit 4 charges supply line while set
// - controller charges only after discharge and SE0
// - bit 6 drives external supply switch level
// - bit 7 selects external fault as indicator
// - enabled rising source edges raise events
// - detach events only with both pull-downs set
// - controller ignores id grounded until settled
// - detection idle when both edge enables clear
// - controller advised to enable both edges; it cannot set falling enables, which come from fall_enable_i
// - session present equals A-session valid signal
// - receive status byte names event sources directly
`timescale 1ns/10ps
`include "orc_defs.svh"
module orc_phy_regs
(
  input  wire logic       sys_clk_i,
  input  wire logic       arst_n_i,
  orc_if.phy              link,
  input  wire logic       vbus_cmp_i,
  input  wire logic       fault_i,
  input  wire logic       a_session_ok_i,
  input  wire logic       session_ended_i,
  input  wire logic       id_grounded_i,
  input  wire logic       downstream_detach_i,
  input  wire logic [1:0] line_state_i,
  input  wire logic [4:0] fall_enable_i,
  output logic            id_sense_enable_o,
  output logic            dplus_pulldown_enable_o,
  output logic            dminus_pulldown_enable_o,
  output logic            supply_discharge_o,
  output logic            supply_charge_o,
  output logic            supply_switch_out_o,
  output logic            external_indicator_select_o
);

  // Register state
  logic [7:0] drc_q;
  logic [7:0] drc_d;
  logic [7:0] ree_q;
  logic [7:0] ree_d;
  logic       ack_q;
  logic [7:0] rdata_q;
  logic [7:0] rdata_d;
  logic [4:0] src_q;
  logic [1:0] ls_q;
  logic       rx_valid_q;
  logic [7:0] rx_byte_q;

  // Write, set or clear of one register
  // Clear takes the ones of the write data as the bits to drop
  function automatic logic [7:0] apply_op(input logic [7:0] cur,
                                          input logic [7:0] wd,
                                          input orc_pkg::orc_op_type op,
                                          input logic [7:0] mask);
    logic [7:0] res;
    res = cur;
    case (op)
      orc_pkg::OP_WRITE: res = wd;
      orc_pkg::OP_SET:   res = cur | wd;
      orc_pkg::OP_CLEAR: res = cur & ~wd;
      default:           res = cur;
    endcase
    return res & mask;
  endfunction

  // Map an address onto the operation it asks for
  // Each register answers at base, base plus one and base plus two
  function automatic orc_pkg::orc_op_type addr_op(input logic [5:0] a,
                                                  input logic [5:0] base);
    orc_pkg::orc_op_type r;
    r = orc_pkg::OP_NONE;
    if (a == base)
      r = orc_pkg::OP_WRITE;
    else if (a == base + 6'h01)
      r = orc_pkg::OP_SET;
    else if (a == base + 6'h02)
      r = orc_pkg::OP_CLEAR;
    return r;
  endfunction

  // Access decode: a request is served once, in the cycle before ack
  // A request to neither register is still answered, and changes nothing
  wire                 take_w  = link.req & ~ack_q;
  wire orc_pkg::orc_op_type drc_op_w = addr_op(link.addr, `ORC_DRC_WR);
  wire orc_pkg::orc_op_type ree_op_w = addr_op(link.addr, `ORC_REE_WR);
  wire                 drc_hit_w = (drc_op_w != orc_pkg::OP_NONE);
  wire                 ree_hit_w = (ree_op_w != orc_pkg::OP_NONE);
  wire                 drc_wr_w  = take_w & link.we & drc_hit_w;
  wire                 ree_wr_w  = take_w & link.we & ree_hit_w;

  // Reserved bits are masked so they stay zero
  assign drc_d = drc_wr_w ? apply_op(drc_q, link.wdata, drc_op_w, `ORC_DRC_MASK)
                          : drc_q;
  assign ree_d = ree_wr_w ? apply_op(ree_q, link.wdata, ree_op_w, `ORC_REE_MASK)
                          : ree_q;

  // Reads return the value at all three addresses; unmapped reads give zero
  assign rdata_d = drc_hit_w ? drc_q :
                   ree_hit_w ? ree_q :
                   8'h00;

  // Register file and access handshake; ack stands one cycle, so a
  // request still high in the ack cycle is not taken a second time
  always_ff @(posedge sys_clk_i or negedge arst_n_i)
  begin
    if (!arst_n_i)
    begin
      drc_q   <= `ORC_DRC_RESET;
      ree_q   <= `ORC_REE_RESET;
      ack_q   <= 1'b0;
      rdata_q <= 8'h00;
    end
    else
    begin
      drc_q   <= drc_d;
      ree_q   <= ree_d;
      ack_q   <= take_w;
      rdata_q <= take_w ? rdata_d : rdata_q;
    end
  end

  assign link.ack   = ack_q;
  assign link.rdata = rdata_q;

  // Supply valid source follows the indicator select; the fault pin
  // replaces the comparator while bit 7 is set
  wire valid_src_w = drc_q[`ORC_B_EXT_IND] ? fault_i : vbus_cmp_i;
  // Id level is not sampled while sensing is off
  wire id_src_w    = drc_q[`ORC_B_ID_SENSE] & id_grounded_i;
  // Host mode needs both line pull-downs
  wire host_mode_w = drc_q[`ORC_B_DP_PD] & drc_q[`ORC_B_DM_PD];

  // Source order is the status byte order, id grounded on top
  wire [4:0] src_w = {id_src_w,
                      session_ended_i,
                      a_session_ok_i,
                      valid_src_w,
                      downstream_detach_i & host_mode_w};

  // A source with neither edge enabled has its detector idle, which
  // lets the detection logic be powered down for that source
  wire [4:0] det_on_w = ree_q[4:0] | fall_enable_i;
  wire [4:0] rise_w   = src_w & ~src_q & ree_q[4:0] & det_on_w;
  // Any enabled rise sets the event flag of the next byte
  wire       event_w  = |rise_w;
  // Line changes are reported even while every source is quiet
  wire       ls_chg_w = (line_state_i != ls_q);

  // Edge history; idle detectors keep a zero history so that
  // re-enabling a source that is already high reports its edge
  always_ff @(posedge sys_clk_i or negedge arst_n_i)
  begin
    if (!arst_n_i)
    begin
      src_q <= 5'h00;
      ls_q  <= 2'h0;
    end
    else
    begin
      src_q <= src_w & det_on_w;
      ls_q  <= line_state_i;
    end
  end

  // Status byte carries sources directly, sent on event or line change
  wire       rx_send_w = event_w | ls_chg_w;
  wire [7:0] rx_word_w = {event_w,
                          line_state_i,
                          src_w};

  // Byte register; a line change alone sends a byte with no event flag
  always_ff @(posedge sys_clk_i or negedge arst_n_i)
  begin
    if (!arst_n_i)
    begin
      rx_valid_q <= 1'b0;
      rx_byte_q  <= 8'h00;
    end
    else
    begin
      rx_valid_q <= rx_send_w;
      if (rx_send_w)
        rx_byte_q <= rx_word_w;
    end
  end

  assign link.rx_valid = rx_valid_q;
  assign link.rx_byte  = rx_byte_q;

  // Pin levels come straight from the register bits, so a pin moves
  // at the edge that raises ack; terminations and id sensing first
  assign id_sense_enable_o           = drc_q[`ORC_B_ID_SENSE];
  assign dplus_pulldown_enable_o     = drc_q[`ORC_B_DP_PD];
  assign dminus_pulldown_enable_o    = drc_q[`ORC_B_DM_PD];

  // Supply charge, discharge, switch and indicator source
  assign supply_discharge_o          = drc_q[`ORC_B_DISCHARGE];
  assign supply_charge_o             = drc_q[`ORC_B_CHARGE];
  assign supply_switch_out_o         = drc_q[`ORC_B_SWITCH];
  assign external_indicator_select_o = drc_q[`ORC_B_EXT_IND];

endmodule

// ### logic/orc_link_ctrl.sv
// Register access over Wishbone was left to the implementer.
`timescale 1ns/10ps
`include "orc_defs.svh"
module orc_link_ctrl
#(
  parameter int ID_SETTLE_CYC = `ORC_ID_SETTLE_MS * (`ORC_CLK_HZ / 1000),
  parameter int SE0_MIN_CYC   = `ORC_SE0_MIN_MS * (`ORC_CLK_HZ / 1000)
)
(
  input  wire logic        sys_clk_i,
  input  wire logic        arst_n_i,
  orc_if.link              phy,
  input  wire logic        wb_cyc_i,
  input  wire logic        wb_stb_i,
  input  wire logic        wb_we_i,
  input  wire logic [7:0]  wb_adr_i,
  input  wire logic [3:0]  wb_sel_i,
  input  wire logic [31:0] wb_dat_i,
  output logic [31:0]      wb_dat_o,
  output logic             wb_ack_o,
  output logic             irq_o
);

  orc_pkg::orc_state_type st_q;
  logic        req_q;
  logic        we_q;
  logic [5:0]  addr_q;
  logic [7:0]  wdata_q;
  logic [7:0]  rd_q;
  logic [7:0]  rx_q;
  logic        disch_q;
  logic        auto_q;
  logic        ended_q;
  logic        id_on_q;
  logic [20:0] id_cnt_q;
  logic [16:0] se0_cnt_q;
  logic [3:0]  irq_st_q;
  logic [3:0]  irq_en_q;
  logic        ack_q;
  logic [31:0] dat_q;
  logic        irq_q;

  // Bus decode
  wire bus_w    = wb_cyc_i & wb_stb_i & ~ack_q;
  wire wr_w     = bus_w & wb_we_i;
  wire cmd_wr_w = wr_w & (wb_adr_i == `ORC_WB_CMD) & (wb_sel_i == 4'hf);
  wire clr_wr_w = wr_w & (wb_adr_i == `ORC_WB_IRQ_CLR) & wb_sel_i[0];
  wire en_wr_w  = wr_w & (wb_adr_i == `ORC_WB_IRQ_EN) & wb_sel_i[0];
  wire [5:0] c_addr_w = wb_dat_i[5:0];
  wire [7:0] c_data_w = wb_dat_i[15:8];
  wire       c_we_w   = wb_dat_i[`ORC_CMD_WE];
  wire       idle_w   = (st_q == orc_pkg::ST_IDLE);

  // Settling and SE0 timers gate what may be believed and sent
  wire id_ok_w  = id_on_q & (id_cnt_q == 21'(ID_SETTLE_CYC));
  wire se0_ok_w = (se0_cnt_q == 17'(SE0_MIN_CYC));
  wire drc_cmd_w = (c_addr_w == `ORC_DRC_WR) | (c_addr_w == `ORC_DRC_SET);
  // Charge only once the supply is discharged and SE0 has lasted
  wire chg_bad_w = c_we_w & drc_cmd_w & c_data_w[`ORC_B_CHARGE]
                   & ~(ended_q & se0_ok_w);
  wire launch_w  = cmd_wr_w & idle_w & ~auto_q & ~chg_bad_w;
  wire refuse_w  = cmd_wr_w & chg_bad_w;
  wire auto_go_w = idle_w & auto_q & ~cmd_wr_w;
  wire done_w    = (st_q == orc_pkg::ST_BUSY) & phy.ack;

  // Id grounded is hidden until the pull-up has settled
  wire [7:0] rx_f_w = {phy.rx_byte[7:5], phy.rx_byte[4] & id_ok_w,
                       phy.rx_byte[3:0]};
  wire ev_w = phy.rx_valid & phy.rx_byte[`ORC_RX_EVENT]
              & (|rx_f_w[4:0]);
  wire end_rise_w = phy.rx_valid & phy.rx_byte[`ORC_EV_ENDED] & ~ended_q;
  wire [3:0] irq_set_w = {end_rise_w & disch_q, refuse_w, ev_w, done_w};

  // Access sequencer: one transfer, then a gap cycle
  always_ff @(posedge sys_clk_i or negedge arst_n_i)
  begin
    if (!arst_n_i)
    begin
      st_q    <= orc_pkg::ST_IDLE;
      req_q   <= 1'b0;
      we_q    <= 1'b0;
      addr_q  <= 6'h00;
      wdata_q <= 8'h00;
      rd_q    <= 8'h00;
    end
    else
    begin
      case (st_q)
        orc_pkg::ST_IDLE:
        begin
          if (launch_w | auto_go_w)
          begin
            st_q    <= orc_pkg::ST_BUSY;
            req_q   <= 1'b1;
            we_q    <= auto_go_w | c_we_w;
            addr_q  <= auto_go_w ? `ORC_DRC_CLR : c_addr_w;
            wdata_q <= auto_go_w ? 8'h08 : c_data_w;
          end
        end
        orc_pkg::ST_BUSY:
        begin
          if (phy.ack)
          begin
            st_q  <= orc_pkg::ST_GAP;
            req_q <= 1'b0;
            rd_q  <= we_q ? rd_q : phy.rdata;
          end
        end
        orc_pkg::ST_GAP: st_q <= orc_pkg::ST_IDLE;
        default: st_q <= orc_pkg::ST_IDLE;
      endcase
    end
  end

  assign phy.req   = req_q;
  assign phy.we    = we_q;
  assign phy.addr  = addr_q;
  assign phy.wdata = wdata_q;

  // Track discharge and id pull-up from what was written
  wire w_done_w  = done_w & we_q;
  wire drc_sel_w = (addr_q == `ORC_DRC_WR);
  wire drc_setw  = (addr_q == `ORC_DRC_SET);
  wire drc_clrw  = (addr_q == `ORC_DRC_CLR);
  wire disch_on_w  = w_done_w & (drc_sel_w | drc_setw) & wdata_q[`ORC_B_DISCHARGE];
  wire disch_off_w = w_done_w & ((drc_sel_w & ~wdata_q[`ORC_B_DISCHARGE])
                     | (drc_clrw & wdata_q[`ORC_B_DISCHARGE]));
  wire id_on_w  = w_done_w & (drc_sel_w | drc_setw) & wdata_q[`ORC_B_ID_SENSE];
  wire id_off_w = w_done_w & ((drc_sel_w & ~wdata_q[`ORC_B_ID_SENSE])
                  | (drc_clrw & wdata_q[`ORC_B_ID_SENSE]));

  // Discharge held until session ended rises, then cleared
  always_ff @(posedge sys_clk_i or negedge arst_n_i)
  begin
    if (!arst_n_i)
    begin
      disch_q <= 1'b0;
      auto_q  <= 1'b0;
      ended_q <= 1'b0;
      rx_q    <= 8'h00;
    end
    else
    begin
      disch_q <= disch_on_w | (disch_q & ~disch_off_w);
      auto_q  <= (auto_q & ~auto_go_w) | (end_rise_w & disch_q);
      ended_q <= phy.rx_valid ? phy.rx_byte[`ORC_EV_ENDED] : ended_q;
      rx_q    <= phy.rx_valid ? rx_f_w : rx_q;
    end
  end

  // Settling timer restarts whenever the pull-up is set again
  always_ff @(posedge sys_clk_i or negedge arst_n_i)
  begin
    if (!arst_n_i)
    begin
      id_on_q   <= 1'b0;
      id_cnt_q  <= 21'h0;
      se0_cnt_q <= 17'h0;
    end
    else
    begin
      id_on_q  <= id_on_w | (id_on_q & ~id_off_w);
      id_cnt_q <= (id_on_w | ~id_on_q) ? 21'h0 :
                  id_ok_w ? id_cnt_q : id_cnt_q + 21'h1;
      if (phy.rx_valid & (phy.rx_byte[6:5] != 2'h0))
        se0_cnt_q <= 17'h0;
      else if (~se0_ok_w & (rx_q[6:5] == 2'h0))
        se0_cnt_q <= se0_cnt_q + 17'h1;
    end
  end

  // Read mux
  wire [31:0] status_w = {8'h00, rx_q, rd_q, 4'h0, se0_ok_w, id_ok_w,
                          disch_q, ~idle_w | auto_q};
  wire [31:0] rmux_w = (wb_adr_i == `ORC_WB_STATUS)   ? status_w :
                       (wb_adr_i == `ORC_WB_IRQ_STAT) ? {28'h0, irq_st_q} :
                       (wb_adr_i == `ORC_WB_IRQ_EN)   ? {28'h0, irq_en_q} :
                       32'h0;

  // Bus slave and interrupt; a new event wins over its clear
  always_ff @(posedge sys_clk_i or negedge arst_n_i)
  begin
    if (!arst_n_i)
    begin
      ack_q    <= 1'b0;
      dat_q    <= 32'h0;
      irq_st_q <= 4'h0;
      irq_en_q <= 4'h0;
      irq_q    <= 1'b0;
    end
    else
    begin
      ack_q    <= bus_w;
      dat_q    <= (bus_w & ~wb_we_i) ? rmux_w : 32'h0;
      irq_st_q <= (irq_st_q & ~(clr_wr_w ? wb_dat_i[3:0] : 4'h0)) | irq_set_w;
      irq_en_q <= en_wr_w ? wb_dat_i[3:0] : irq_en_q;
      irq_q    <= |(irq_st_q & irq_en_q);
    end
  end

  assign wb_ack_o = ack_q;
  assign wb_dat_o = dat_q;
  assign irq_o    = irq_q;

endmodule

// ### tb/orc_properties.sv
`timescale 1ns/10ps
module orc_properties
(
  input  wire logic       sys_clk_i,
  input  wire logic       arst_n_i,
  input  wire logic       req,
  input  wire logic       we,
  input  wire logic [5:0] addr,
  input  wire logic [7:0] wdata,
  input  wire logic       ack,
  input  wire logic [7:0] rdata,
  input  wire logic       rx_valid,
  input  wire logic [7:0] rx_byte
);
  logic [7:0] drc_q;
  logic [7:0] drc_d;
  logic [7:0] ree_q;
  logic [7:0] ree_d;
  wire logic  wr_take = req & ~ack & we;

  // Offset within a triple: plain write, set ones, clear ones
  function automatic logic [7:0] upd(input logic [7:0] o, input logic [1:0] k,
                                     input logic [7:0] d, input logic [7:0] m);
    upd = (k == 2'h0) ? (d & m) : (k == 2'h1) ? (o | (d & m)) : (o & ~d);
  endfunction

  // Shadow copies follow writes at the accepting edge
  assign drc_d = (wr_take && addr >= 6'h0a && addr <= 6'h0c) ?
                 upd(drc_q, 2'(addr - 6'h0a), wdata, 8'hdf) : drc_q;
  assign ree_d = (wr_take && addr >= 6'h0d && addr <= 6'h0f) ?
                 upd(ree_q, 2'(addr - 6'h0d), wdata, 8'h1f) : ree_q;

  // Shadow registers start at the documented reset values
  always_ff @(posedge sys_clk_i or negedge arst_n_i)
  begin
    if (!arst_n_i)
    begin
      drc_q <= 8'h06;
      ree_q <= 8'h1f;
    end
    else
    begin
      drc_q <= drc_d;
      ree_q <= ree_d;
    end
  end

  default clocking cb @(posedge sys_clk_i);
  endclocking
  default disable iff (!arst_n_i);

  sequence s_take;
    req && !ack;
  endsequence
  sequence s_answer;
    ack ##1 (!ack && !req);
  endsequence

  // Handshake: one-cycle answer, then the request is released
  AST_ACK_NEXT: assert property (s_take |=> s_answer)
    else $error("register access not answered in one cycle");
  AST_ACK_CAUSE: assert property ($rose(ack) |-> $past(req) && req)
    else $error("acknowledge without request");
  AST_REQ_HOLD: assert property (s_take |=> req && $stable(addr) && $stable(we) && $stable(wdata))
    else $error("request changed before acknowledge");
  // Read data follows the written, set and cleared history
  AST_DRC_READ: assert property (ack && !we && addr inside {[6'h0a:6'h0c]} |-> rdata == drc_q)
    else $error("control register read mismatch");
  AST_REE_READ: assert property (ack && !we && addr inside {[6'h0d:6'h0f]} |-> rdata == ree_q)
    else $error("rising enable read mismatch");
  AST_REE_RSVD: assert property (ack && !we && addr inside {[6'h0d:6'h0f]} |-> rdata[7:5] == 3'h0)
    else $error("reserved enable bits read nonzero");
  AST_UNMAPPED: assert property (ack && !we && !(addr inside {[6'h0a:6'h0f]}) |-> rdata == 8'h00)
    else $error("unmapped read nonzero");
  // Gated sources stay quiet in the status byte
  AST_HOST_DETACH: assert property (rx_valid && !(drc_q[1] && drc_q[2]) && !($past(drc_q[1]) && $past(drc_q[2])) |-> !rx_byte[0])
    else $error("detach reported outside host mode");
  AST_ID_GATE: assert property (rx_valid && !drc_q[0] && !$past(drc_q[0]) |-> !rx_byte[4])
    else $error("id grounded reported while sampling off");
endmodule

// ### tb/otg_control_and_rise_irq_enable_bench.sv
`timescale 1ns/10ps
`include "orc_defs.svh"
module otg_control_and_rise_irq_enable_bench;
  logic        sys_clk_i;
  logic        arst_n_i;
  logic        wb_cyc;
  logic        wb_stb;
  logic        wb_we;
  logic [7:0]  wb_adr;
  logic [31:0] wb_dat;
  logic [31:0] wb_dat_o;
  logic        wb_ack_o;
  logic        irq_o;
  logic [4:0]  src;
  logic        fault;
  logic [1:0]  line_state;
  logic [4:0]  fall_en;
  logic [6:0]  pins;
  logic [7:0]  drc_m;
  logic [7:0]  ree_m;
  logic [31:0] q;
  logic [7:0]  r;
  int          mismatches;
  int          comparisons;
  int          seed;
  int          rv;

  orc_if bus();
  orc_phy_regs u_orc_phy_regs (.sys_clk_i(sys_clk_i), .arst_n_i(arst_n_i), .link(bus),
    .vbus_cmp_i(src[1]), .fault_i(fault), .a_session_ok_i(src[2]), .session_ended_i(src[3]),
    .id_grounded_i(src[4]), .downstream_detach_i(src[0]), .line_state_i(line_state),
    .fall_enable_i(fall_en), .id_sense_enable_o(pins[0]), .dplus_pulldown_enable_o(pins[1]),
    .dminus_pulldown_enable_o(pins[2]), .supply_discharge_o(pins[3]),
    .supply_charge_o(pins[4]), .supply_switch_out_o(pins[5]),
    .external_indicator_select_o(pins[6]));
  orc_link_ctrl #(.ID_SETTLE_CYC(20), .SE0_MIN_CYC(10)) u_orc_link_ctrl (
    .sys_clk_i(sys_clk_i), .arst_n_i(arst_n_i), .phy(bus), .wb_cyc_i(wb_cyc),
    .wb_stb_i(wb_stb), .wb_we_i(wb_we), .wb_adr_i(wb_adr), .wb_sel_i(4'hf),
    .wb_dat_i(wb_dat), .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o), .irq_o(irq_o));
  orc_properties u_orc_properties (.sys_clk_i(sys_clk_i), .arst_n_i(arst_n_i),
    .req(bus.req), .we(bus.we), .addr(bus.addr), .wdata(bus.wdata), .ack(bus.ack),
    .rdata(bus.rdata), .rx_valid(bus.rx_valid), .rx_byte(bus.rx_byte));

  // Expected register value after a write, set or clear
  function automatic logic [7:0] upd(input logic [7:0] o, input logic [1:0] k,
                                     input logic [7:0] d, input logic [7:0] m);
    upd = (k == 2'h0) ? (d & m) : (k == 2'h1) ? (o | (d & m)) : (o & ~d);
  endfunction

  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    comparisons++;
    if (seen !== exp)
    begin
      mismatches++;
      $display("CHECK FAILED at %0t: saw %h expected %h", $time, seen, exp);
    end
  endtask

  task automatic results();
    if (mismatches == 0 && comparisons > 0)
      $display("ALL TESTS PASSED");
    else
      $display("TESTS FAILED");
    $finish;
  endtask

  // Classic single Wishbone cycle; held until ack is sampled
  task automatic wb(input logic w, input logic [7:0] a, input logic [31:0] d,
                    output logic [31:0] qo);
    int n;
    n = 0;
    wb_cyc <= 1'b1;
    wb_stb <= 1'b1;
    wb_we  <= w;
    wb_adr <= a;
    wb_dat <= d;
    @(posedge sys_clk_i);
    while (wb_ack_o !== 1'b1 && n < 50)
    begin
      @(posedge sys_clk_i);
      n++;
    end
    qo = wb_dat_o;
    if (n >= 50)
      mismatches++;
    wb_cyc <= 1'b0;
    wb_stb <= 1'b0;
    @(posedge sys_clk_i);
  endtask

  // Transceiver access by command, then poll busy; returns read byte
  task automatic phy(input logic w, input logic [5:0] a, input logic [7:0] d,
                     output logic [7:0] ro);
    logic [31:0] s;
    int          n;
    n = 0;
    wb(1'b1, `ORC_WB_CMD, {15'h0, w, d, 2'b00, a}, s);
    do
    begin
      wb(1'b0, `ORC_WB_STATUS, 32'h0, s);
      n++;
    end
    while (s[0] !== 1'b0 && n < 20);
    if (n >= 20)
      mismatches++;
    ro = s[15:8];
  endtask

  // Clear flags, raise one source, look for the event, lower it again;
  // with no event a line change sends a byte showing the source level
  task automatic ev(input int k, input logic exp, input logic lvl);
    wb(1'b1, `ORC_WB_IRQ_CLR, 32'hf, q);
    src[k] <= 1'b1;
    repeat (6) @(posedge sys_clk_i);
    line_state <= exp ? 2'b00 : 2'b10;
    wb(1'b0, `ORC_WB_IRQ_STAT, 32'h0, q);
    check(q[1], exp);
    wb(1'b0, `ORC_WB_STATUS, 32'h0, q);
    check({q[23], q[16 + k]}, {exp, lvl});
    src[k] <= 1'b0;
    line_state <= 2'b00;
    repeat (6) @(posedge sys_clk_i);
  endtask

  // Free-running system clock
  initial
  begin
    sys_clk_i = 1'b0;
    forever #20 sys_clk_i = ~sys_clk_i;
  end

  // Hang guard
  initial
  begin
    repeat (40000) @(posedge sys_clk_i);
    mismatches++;
    results();
  end

  // Main sequence
  initial
  begin
    seed = 32;
    arst_n_i = 1'b0;
    {wb_cyc, wb_stb, wb_we, wb_adr, wb_dat} = '0;
    {src, fault, line_state, fall_en} = '0;
    repeat (8) @(posedge sys_clk_i);
    arst_n_i <= 1'b1;
    @(posedge sys_clk_i);
    check(pins, 7'h06);
    for (int i = 0; i < 6; i++)
    begin
      phy(1'b0, 6'(6'h0a + i), 8'h00, r);
      check(r, (i < 3) ? 8'h06 : 8'h1f);
    end
    wb(1'b0, `ORC_WB_STATUS, 32'h0, q);
    check(q[2], 1'b0);
    phy(1'b0, 6'h3f, 8'h00, r);
    check(r, 8'h00);
    wb(1'b0, 8'h20, 32'h0, q);
    check(q, 32'h0);
    // Random write, set and clear traffic with readback at any alias
    drc_m = 8'h06;
    ree_m = 8'h1f;
    for (int i = 0; i < 40; i++)
    begin
      rv = $random(seed);
      if (rv[3:2] == 2'h3)
        rv[3:2] = 2'h0;
      if (rv[5:4] == 2'h3)
        rv[5:4] = 2'h2;
      if (rv[0])
      begin
        if (rv[3:2] != 2'h2)
          rv[12] = 1'b0;
        phy(1'b1, 6'(6'h0a + rv[3:2]), rv[15:8], r);
        drc_m = upd(drc_m, rv[3:2], rv[15:8], 8'hdf);
        phy(1'b0, 6'(6'h0a + rv[5:4]), 8'h00, r);
        check(r, drc_m);
      end
      else
      begin
        phy(1'b1, 6'(6'h0d + rv[3:2]), rv[15:8], r);
        ree_m = upd(ree_m, rv[3:2], rv[15:8], 8'h1f);
        phy(1'b0, 6'(6'h0d + rv[5:4]), 8'h00, r);
        check(r, ree_m);
      end
      check(pins, {drc_m[7:6], drc_m[4:0]});
    end
    // Each source enabled, disabled, and detach outside host mode
    phy(1'b1, 6'h0a, 8'h07, r);
    repeat (30) @(posedge sys_clk_i);
    wb(1'b0, `ORC_WB_STATUS, 32'h0, q);
    check(q[2], 1'b1);
    for (int en = 1; en >= 0; en--)
      for (int k = 0; k < 6; k++)
      begin
        phy(1'b1, 6'h0a, (k == 5) ? 8'h05 : 8'h07, r);
        phy(1'b1, 6'h0d, en ? 8'(1 << (k % 5)) : 8'h00, r);
        repeat (25) @(posedge sys_clk_i); // Id pull-up written again, let it settle
        ev(k % 5, en && k < 5, k < 5);
      end
    // External indicator replaces the comparator
    phy(1'b1, 6'h0a, 8'h86, r);
    phy(1'b1, 6'h0d, 8'h1f, r);
    fall_en <= 5'h1f;
    fault <= 1'b1;
    src[4] <= 1'b1; // Sampling off, must stay out of the byte
    repeat (6) @(posedge sys_clk_i);
    wb(1'b0, `ORC_WB_STATUS, 32'h0, q);
    check(q[17], 1'b1);
    fault <= 1'b0;
    src[4] <= 1'b0;
    // Interrupt raised, cleared, then masked
    wb(1'b1, `ORC_WB_IRQ_EN, 32'h2, q);
    ev(2, 1'b1, 1'b1);
    check(irq_o, 1'b1);
    wb(1'b1, `ORC_WB_IRQ_CLR, 32'h2, q);
    repeat (3) @(posedge sys_clk_i);
    check(irq_o, 1'b0);
    wb(1'b1, `ORC_WB_IRQ_EN, 32'h0, q);
    ev(2, 1'b1, 1'b1);
    check(irq_o, 1'b0);
    // Discharge stops itself once the session has ended
    wb(1'b1, `ORC_WB_IRQ_CLR, 32'hf, q);
    phy(1'b1, 6'h0b, 8'h08, r);
    check(pins[3], 1'b1);
    src[3] <= 1'b1;
    repeat (30) @(posedge sys_clk_i);
    check(pins[3], 1'b0);
    wb(1'b0, `ORC_WB_IRQ_STAT, 32'h0, q);
    check(q[3], 1'b1);
    // Charge refused without a long enough single-ended zero
    line_state <= 2'b01;
    repeat (5) @(posedge sys_clk_i);
    phy(1'b1, 6'h0b, 8'h10, r);
    check(pins[4], 1'b0);
    wb(1'b0, `ORC_WB_IRQ_STAT, 32'h0, q);
    check(q[2], 1'b1);
    line_state <= 2'b00;
    repeat (15) @(posedge sys_clk_i);
    phy(1'b1, 6'h0b, 8'h10, r);
    check(pins[4], 1'b1);
    results();
  end
endmodule
